// [core/vsig_irq_gen.sv]
// two-generator status interrupt logic
`timescale 1ns/100ps
`include "vsig_map.svh"
module vsig_irq_gen #(
  // generator count; select and acknowledge ports carry exactly two
  parameter int NUM_GEN = `VSIG_NUM_GEN
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  // status conditions
  input  wire logic [15:0]          status_i,
  // configuration command
  input  wire logic                 irq_config_command_i,
  input  wire logic                 generator_select_i,
  input  wire vsig_pkg::vsig_mask_t event_mask_i,
  input  wire vsig_pkg::vsig_prio_t priority_i,
  // reload command
  input  wire logic                 mask_reload_command_i,
  // queries
  input  wire logic                 query_select_i,
  output logic [15:0]               event_mask_query_o,
  output logic [2:0]                request_line_query_o,
  // acknowledge per generator
  input  wire logic [1:0]           iack_i,
  // request lines 1..7, bit0 unused and held low
  output logic [7:0]                irq_line_o
);
  localparam int NG = NUM_GEN;
  vsig_pkg::vsig_mask_t mask_r [NG];
  vsig_pkg::vsig_mask_t saved_r [NG];
  vsig_pkg::vsig_prio_t prio_r [NG];
  logic                 pend_r [NG];
  logic [15:0]          stat_s1_r;
  logic [15:0]          stat_s2_r;
  logic [7:0]           irq_nxt;

  // ==========================================================
  // parameter check
  // one select bit and two acknowledge bits cannot serve any other count
  if (NUM_GEN != 2) begin : gen_bad_num
    $error("NUM_GEN must be 2");
  end

  // ==========================================================
  // status synchroniser
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_s1_r <= `VSIG_STAT_RST;
      stat_s2_r <= `VSIG_STAT_RST;
    end else begin
      stat_s1_r <= status_i;
      stat_s2_r <= stat_s1_r;
    end
  end

  // ==========================================================
  // per-generator state; no acquisition control lives here, so reload cannot disturb it
  for (genvar g = 0; g < NG; g++) begin : gen_g
    logic sel;
    logic hit;
    assign sel = irq_config_command_i && (generator_select_i == 1'(g));
    assign hit = |(stat_s2_r & mask_r[g] & `VSIG_MASK_KEEP) && (prio_r[g] != `VSIG_PRIO_OFF);

    // configuration beats acknowledge, acknowledge beats reload
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        mask_r[g] <= `VSIG_MASK_RST;
      end else if (sel) begin
        mask_r[g] <= event_mask_i & `VSIG_MASK_KEEP;
      end else if (iack_i[g]) begin
        mask_r[g] <= `VSIG_MASK_RST;
      end else if (mask_reload_command_i) begin
        mask_r[g] <= saved_r[g];
      end
    end

    // shadow of the last programmed mask, untouched by acknowledge
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        saved_r[g] <= `VSIG_MASK_RST;
      end else if (sel) begin
        saved_r[g] <= event_mask_i & `VSIG_MASK_KEEP;
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        prio_r[g] <= `VSIG_PRIO_RST;
      end else if (sel) begin
        prio_r[g] <= priority_i;
      end
    end

    // acknowledge wins over a coinciding event: the mask clears on that edge, so nothing may follow
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        pend_r[g] <= 1'b0;
      end else if (hit && !iack_i[g]) begin
        pend_r[g] <= 1'b1;
      end else if (iack_i[g]) begin
        pend_r[g] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // request line drive
  always_comb begin
    irq_nxt = 8'h00;
    for (int g = 0; g < NG; g++) begin
      if (pend_r[g] && !iack_i[g] && prio_r[g] != `VSIG_PRIO_OFF) begin
        irq_nxt[prio_r[g]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_line_o <= `VSIG_IRQ_RST;
    end else begin
      irq_line_o <= irq_nxt;
    end
  end

  // ==========================================================
  // readback
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      event_mask_query_o <= `VSIG_MASK_RST;
    end else begin
      event_mask_query_o <= mask_r[query_select_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      request_line_query_o <= `VSIG_PRIO_RST;
    end else begin
      request_line_query_o <= prio_r[query_select_i];
    end
  end

  // ==========================================================
  // checks
  // configuration reaches the selected generator only
  config_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_config_command_i && !generator_select_i
    |=> mask_r[0] == ($past(event_mask_i) & `VSIG_MASK_KEEP) && prio_r[0] == $past(priority_i))
    else $error("config not applied to generator 0");
  config1_apply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_config_command_i && generator_select_i
    |=> mask_r[1] == ($past(event_mask_i) & `VSIG_MASK_KEEP) && prio_r[1] == $past(priority_i))
    else $error("config not applied to generator 1");
  other_untouched_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_config_command_i && !generator_select_i |=> $stable(prio_r[1]) && $stable(saved_r[1]))
    else $error("other generator changed");
  other0_untouched_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_config_command_i && generator_select_i |=> $stable(prio_r[0]) && $stable(saved_r[0]))
    else $error("generator 0 changed by config of generator 1");
  saved_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_config_command_i && !generator_select_i |=> saved_r[0] == ($past(event_mask_i) & `VSIG_MASK_KEEP))
    else $error("mask copy not taken");

  // only the upper status byte may interrupt
  low_byte_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mask_r[0][7:0] == 8'h00 && mask_r[1][7:0] == 8'h00)
    else $error("low mask byte set");
  low_byte_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (stat_s2_r & `VSIG_MASK_KEEP) == `VSIG_STAT_RST |-> !gen_g[0].hit && !gen_g[1].hit)
    else $error("low status byte raised an event");

  // acknowledge clears, reload restores
  iack_clears_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    iack_i[1] && !irq_config_command_i |=> mask_r[1] == `VSIG_MASK_RST)
    else $error("ack did not clear mask");
  iack0_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    iack_i[0] && !(irq_config_command_i && !generator_select_i) |=> mask_r[0] == `VSIG_MASK_RST)
    else $error("ack did not clear mask of generator 0");
  reload_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mask_reload_command_i && !irq_config_command_i && iack_i == 2'b00
    |=> mask_r[0] == $past(saved_r[0]))
    else $error("reload did not restore mask");
  reload1_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mask_reload_command_i && !irq_config_command_i && iack_i == 2'b00
    |=> mask_r[1] == $past(saved_r[1]))
    else $error("reload did not restore mask of generator 1");

  // request lines
  prio_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_line_o[0] == 1'b0)
    else $error("line zero driven");
  prio_zero_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    prio_r[0] == `VSIG_PRIO_OFF && prio_r[1] == `VSIG_PRIO_OFF |=> irq_line_o == `VSIG_IRQ_RST)
    else $error("line driven with both generators off");
  hold_line_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pend_r[0] && iack_i == 2'b00 && !irq_config_command_i && prio_r[0] != `VSIG_PRIO_OFF
    |=> irq_line_o[$past(prio_r[0])])
    else $error("request dropped before ack");
  event_raise_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    gen_g[1].hit && iack_i == 2'b00 |=> pend_r[1])
    else $error("event missed");
  event_raise0_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    gen_g[0].hit && !iack_i[0] |=> pend_r[0])
    else $error("event of generator 0 missed");
  ack_drops_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    iack_i[0] |=> !pend_r[0])
    else $error("pending kept after ack");
  pend_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pend_r[1] && !iack_i[1] |=> pend_r[1])
    else $error("pending dropped without ack");
  no_line_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pend_r[0] && !pend_r[1] |=> irq_line_o == `VSIG_IRQ_RST)
    else $error("line driven with nothing pending");

  // readback of the queried generator
  readback_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> request_line_query_o == $past(prio_r[query_select_i]))
    else $error("bad priority readback");
  mask_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> event_mask_query_o == $past(mask_r[query_select_i]))
    else $error("bad mask readback");

  // ==========================================================
  // main scenarios
  cfg_c: cover property (@(posedge clk_i) irq_config_command_i && generator_select_i);
  irq_c: cover property (@(posedge clk_i) irq_line_o[7]);
  ack_c: cover property (@(posedge clk_i) pend_r[0] && iack_i[0]);
  reload_c: cover property (@(posedge clk_i) mask_reload_command_i && mask_r[0] != saved_r[0]);
  both_c: cover property (@(posedge clk_i) irq_line_o[3] && irq_line_o[7]);
endmodule : vsig_irq_gen

// [shared/vsig_map.svh]
// constants for the status interrupt generator
// Overview of operation
// - Two independent generators each drive any one of seven request lines when an enabled status condition occurs.
// - A configuration command carries a generator select, an event mask and a priority, applied to that generator only.
// - Mask and priority of the queried generator are read back separately.
// - The acknowledge cycle for a generator clears its event mask, stopping further interrupts.
// - A reload command restores cleared masks from the copy last programmed.
// - A reload never stops or aborts a running acquisition.
// - The generator select names generator zero or one only.
// - Only status bits 8 to 15 are maskable, so the mask has the form 0xMM00.
// - The lower eight status bits never interrupt and their mask bits are held at zero.
// - Priority 0 disables a generator and 1 to 7 select that request line, 7 highest.
`ifndef VSIG_MAP_SVH
`define VSIG_MAP_SVH
`define VSIG_NUM_GEN      2
`define VSIG_MASK_LSB     8
`define VSIG_MASK_KEEP    16'hFF00
`define VSIG_MASK_RST     16'h0000
`define VSIG_PRIO_RST     3'h0
`define VSIG_PRIO_OFF     3'h0
`define VSIG_STAT_RST     16'h0000
`define VSIG_IRQ_RST      8'h00
`endif

// [shared/vsig_pkg.sv]
// types for the status interrupt generator
package vsig_pkg;
  typedef logic [15:0] vsig_mask_t;
  typedef logic [2:0]  vsig_prio_t;
endpackage : vsig_pkg

// [verification/vsig_host_model.sv]
// host model: acknowledges the request line of each generator
`timescale 1ns/100ps
module vsig_host_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // handler side
  input  wire logic [1:0] ack_en_i,
  input  wire logic [7:0] irq_line_i,
  input  wire logic [2:0] line0_i,
  input  wire logic [2:0] line1_i,
  output logic      [1:0] iack_o
);
  // ==========================================================
  // acknowledge cycles
  // one-cycle acknowledge; re-ack after a gap if the line lingers
  always_ff @(negedge clk_i) begin
    if (sys_rst_i) begin
      iack_o <= 2'h0;
    end else begin
      iack_o[0] <= ack_en_i[0] && irq_line_i[line0_i] && !iack_o[0];
      iack_o[1] <= ack_en_i[1] && irq_line_i[line1_i] && !iack_o[1];
    end
  end
endmodule : vsig_host_model

// [verification/tb.sv]
// self-checking bench for the status interrupt generator
`timescale 1ns/100ps
module tb;
  logic clk_i = 0, sys_rst_i = 1, cfg = 0, gsel = 0, rld = 0, qsel = 0;
  logic [1:0] ack_en = 2'h0;
  logic [15:0] status = 16'h0000, mask = 16'h0000, qmask;
  logic [2:0] prio = 3'h0, qprio;
  logic [1:0] iack;
  logic [7:0] irq;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  vsig_irq_gen i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .status_i(status), .irq_config_command_i(cfg),
    .generator_select_i(gsel), .event_mask_i(mask), .priority_i(prio), .mask_reload_command_i(rld),
    .query_select_i(qsel), .event_mask_query_o(qmask), .request_line_query_o(qprio), .iack_i(iack),
    .irq_line_o(irq));
  vsig_host_model i_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ack_en_i(ack_en), .irq_line_i(irq),
    .line0_i(3'h3), .line1_i(3'h7), .iack_o(iack));
  // ==========================================================
  // compare and drive helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic setup(input logic g, input logic [15:0] m, input logic [2:0] p);
    @(negedge clk_i);
    {gsel, mask, prio, cfg} = {g, m, p, 1'b1};
    @(negedge clk_i);
    cfg = 0;
  endtask : setup
  task automatic query(input logic g, input logic [15:0] m, input logic [2:0] p);
    @(negedge clk_i);
    qsel = g;
    repeat (2) @(negedge clk_i);
    chk("mask", m, qmask);
    chk("prio", {13'h0, p}, {13'h0, qprio});
  endtask : query
  // ==========================================================
  // scenarios
  task automatic t_config;
    setup(0, 16'hFF55, 3'h3);
    setup(1, 16'h8000, 3'h7);
    query(0, 16'hFF00, 3'h3);
    query(1, 16'h8000, 3'h7);
    $display("test config done");
  endtask : t_config
  task automatic t_irq;
    status = 16'h0100;
    repeat (8) @(negedge clk_i);
    chk("irq", 16'h0008, {8'h00, irq});
    status = 16'h0000;
    ack_en <= 2'b01;
    repeat (4) @(negedge clk_i);
    chk("irq", 16'h0000, {8'h00, irq});
    ack_en <= 2'b00;
    query(0, 16'h0000, 3'h3);
    query(1, 16'h8000, 3'h7);
    rld = 1'b1;
    @(negedge clk_i);
    rld = 0;
    query(0, 16'hFF00, 3'h3);
    query(1, 16'h8000, 3'h7);
    chk("irq", 16'h0000, {8'h00, irq});
    $display("test irq done");
  endtask : t_irq
  // both generators fire on bit 15, then are acknowledged one by one
  task automatic t_two;
    status = 16'h8000;
    repeat (8) @(negedge clk_i);
    chk("irq", 16'h0088, {8'h00, irq});
    ack_en <= 2'b10;
    repeat (4) @(negedge clk_i);
    chk("irq", 16'h0008, {8'h00, irq});
    status = 16'h0000;
    ack_en <= 2'b01;
    repeat (4) @(negedge clk_i);
    chk("irq", 16'h0000, {8'h00, irq});
    ack_en <= 2'b00;
    query(1, 16'h0000, 3'h7);
    query(0, 16'h0000, 3'h3);
    $display("test two done");
  endtask : t_two
  task automatic t_off;
    setup(0, 16'hFF00, 3'h3);
    status = 16'h00FF;
    repeat (8) @(negedge clk_i);
    chk("irq", 16'h0000, {8'h00, irq});
    setup(0, 16'hFF00, 3'h0);
    setup(1, 16'h8000, 3'h0);
    status = 16'h80FF;
    repeat (8) @(negedge clk_i);
    chk("irq", 16'h0000, {8'h00, irq});
    query(1, 16'h8000, 3'h0);
    status = 16'h0000;
    $display("test off done");
  endtask : t_off
  // ==========================================================
  // run control
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // ceiling well above the roughly 90 cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 0;
    query(0, 16'h0000, 3'h0);
    t_config();
    t_irq();
    t_two();
    t_off();
    end_sim();
  end
endmodule : tb
